// *** flash_front_regs.vh ***
// constants for the serial flash command and read front end
`ifndef FLASH_FRONT_REGS_VH
`define FLASH_FRONT_REGS_VH
`define OP_READ_FAST 8'h0B
`define OP_READ_SLOW 8'h03
`define OP_READ_DUAL 8'h3B
`define OP_PAGE_ERASE 8'h81
`define OP_BLK4_ERASE 8'h20
`define OP_BLK32_ERASE_A 8'h52
`define OP_BLK32_ERASE_B 8'hD8
`define OP_CHIP_ERASE_A 8'h60
`define OP_CHIP_ERASE_B 8'hC7
`define OP_CHIP_ERASE_C 8'h62
`define OP_PROGRAM 8'h02
`define OP_WR_ENABLE 8'h06
`define OP_WR_DISABLE 8'h04
`define OP_SEC_PROGRAM 8'h9B
`define OP_SEC_READ 8'h77
`define OP_STATUS_RD 8'h05
`define OP_STATUS_WR1 8'h01
`define OP_STATUS_WR2 8'h31
`define OP_RESET 8'hF0
`define RESET_CONFIRM 8'hD0
`define OP_ID_READ 8'h9F
`define OP_ID_LEGACY 8'h15
`define OP_DEEP_PD 8'hB9
`define OP_RESUME_PD 8'hAB
`define OP_ULTRA_PD 8'h79
`define ADDR_WIDTH 15
`define ADDR_TOP 15'h7FFF
`define OPCODE_BITS 6'h08
`define ADDR_END_BITS 6'h20
`define DUMMY1_END_BITS 6'h28
`define DUMMY2_END_BITS 6'h30
`define CMD_RESET_VAL 8'h00
`endif

// *** pin_sync.v ***
// two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module pin_sync #(
	parameter WIDTH = 3
) (
	input wire mclk,
	input wire arst_n,
	input wire ce,
	input wire [WIDTH-1:0] async_in,
	input wire [WIDTH-1:0] rst_val,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_ff;
	reg [WIDTH-1:0] sync_ff;
	// flops hold the input xor its idle level, so a constant zero reset
	// still shows the idle level on the output with no false edge
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			always @(posedge mclk or negedge arst_n) begin
				if (!arst_n) begin
					meta_ff[i] <= 1'b0;
					sync_ff[i] <= 1'b0;
				end else if (ce) begin
					meta_ff[i] <= async_in[i] ^ rst_val[i];
					sync_ff[i] <= meta_ff[i];
				end
			end
		end
	endgenerate
	assign sync_out = sync_ff ^ rst_val;
endmodule

// *** array_rom.v ***
// read-only model of the 32 KiB array, one registered byte port
`timescale 1ns/1ns
`include "flash_front_regs.vh"
module array_rom #(
	parameter AW = `ADDR_WIDTH
) (
	input wire mclk,
	input wire ce,
	input wire [AW-1:0] rd_addr,
	output reg [7:0] rd_data
);
	reg [7:0] mem [0:(1<<AW)-1];
	integer k;
	// pattern fill: low address byte xor high, easy to check in a bench
	initial begin
		for (k = 0; k < (1<<AW); k = k + 1) begin
			mem[k] = k[7:0] ^ k[15:8];
		end
	end
	always @(posedge mclk) begin
		if (ce) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule

// *** flash_front.v ***
// serial flash front end: command framing, decode and array read
`timescale 1ns/1ns
`include "flash_front_regs.vh"
module flash_front #(
	parameter AW = `ADDR_WIDTH
) (
	input wire mclk,
	input wire arst_n,
	input wire ce,
	input wire cs_n,
	input wire sck,
	input wire si_in,
	output reg si_out,
	output reg si_oe,
	output reg so_out,
	output reg so_oe,
	output reg [7:0] cmd_code,
	output reg [AW-1:0] cmd_addr,
	output reg cmd_valid,
	output reg [7:0] wr_data,
	output reg wr_data_valid,
	output reg cmd_abort
);
	// ==========================================
	// states
	localparam [5:0] ST_IDLE = 6'b000001;
	localparam [5:0] ST_OPC = 6'b000010;
	localparam [5:0] ST_HDR = 6'b000100;
	localparam [5:0] ST_DATA = 6'b001000;
	localparam [5:0] ST_READ = 6'b010000;
	localparam [5:0] ST_IGN = 6'b100000;

	// command class
	localparam [2:0] CL_NONE = 3'd0;
	localparam [2:0] CL_OPONLY = 3'd1;
	localparam [2:0] CL_ADDR = 3'd2;
	localparam [2:0] CL_ADDR_DATA = 3'd3;
	localparam [2:0] CL_DATA = 3'd4;
	localparam [2:0] CL_OUT = 3'd5;

	// ==========================================
	// opcode table, used for class and header length
	function [2:0] op_class;
		input [7:0] op;
		begin
			case (op)
				`OP_READ_FAST, `OP_READ_SLOW, `OP_READ_DUAL, `OP_SEC_READ: op_class = CL_ADDR;
				`OP_BLK4_ERASE, `OP_BLK32_ERASE_A, `OP_BLK32_ERASE_B: op_class = CL_ADDR;
				`OP_PAGE_ERASE: op_class = CL_ADDR;
				`OP_PROGRAM, `OP_SEC_PROGRAM: op_class = CL_ADDR_DATA;
				`OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B, `OP_CHIP_ERASE_C,
				`OP_WR_ENABLE, `OP_WR_DISABLE,
				`OP_DEEP_PD, `OP_RESUME_PD, `OP_ULTRA_PD: op_class = CL_OPONLY;
				`OP_STATUS_WR1, `OP_STATUS_WR2, `OP_RESET: op_class = CL_DATA;
				`OP_STATUS_RD, `OP_ID_READ, `OP_ID_LEGACY: op_class = CL_OUT;
				default: op_class = CL_NONE;
			endcase
		end
	endfunction

	function [5:0] hdr_end;
		input [7:0] op;
		begin
			case (op)
				`OP_READ_FAST, `OP_READ_DUAL: hdr_end = `DUMMY1_END_BITS;
				`OP_SEC_READ: hdr_end = `DUMMY2_END_BITS;
				default: hdr_end = `ADDR_END_BITS;
			endcase
		end
	endfunction

	// ==========================================
	// pin synchronisers
	wire [2:0] pins_s;
	pin_sync #(
		.WIDTH(3)
	) u_sync (
		.mclk(mclk),
		.arst_n(arst_n),
		.ce(ce),
		.async_in({cs_n, sck, si_in}),
		.rst_val(3'b100),
		.sync_out(pins_s)
	);
	wire cs_s = ~pins_s[2];
	wire sck_s = pins_s[1];
	wire si_s = pins_s[0];

	reg sck_d_ff;
	reg cs_d_ff;
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sck_d_ff <= 1'b0;
			cs_d_ff <= 1'b0;
		end else if (ce) begin
			sck_d_ff <= sck_s;
			cs_d_ff <= cs_s;
		end
	end
	wire rise = cs_s & sck_s & ~sck_d_ff;
	wire fall = cs_s & ~sck_s & sck_d_ff;
	wire sel_start = cs_s & ~cs_d_ff;
	wire sel_end = ~cs_s & cs_d_ff;

	// ==========================================
	// shifter and sequencing
	reg [5:0] state_ff;
	reg [5:0] bitcnt_ff;
	reg [7:0] sh_ff;
	reg [7:0] op_ff;
	reg [AW-1:0] addr_ff;
	reg dual_ff;
	reg [7:0] obyte_ff;
	reg [2:0] opos_ff;
	reg fetch_ff;
	reg fetch2_ff;
	wire [7:0] rom_q;

	wire [7:0] sh_nxt = {sh_ff[6:0], si_s};
	wire byte_done = (bitcnt_ff[2:0] == 3'd7);
	wire [AW-1:0] nxt_addr = addr_ff + 1'b1;

	array_rom #(
		.AW(AW)
	) u_rom (
		.mclk(mclk),
		.ce(ce),
		.rd_addr(addr_ff),
		.rd_data(rom_q)
	);

	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= ST_IDLE;
			bitcnt_ff <= 6'h00;
			sh_ff <= 8'h00;
			op_ff <= `CMD_RESET_VAL;
			addr_ff <= {AW{1'b0}};
			dual_ff <= 1'b0;
			obyte_ff <= 8'h00;
			opos_ff <= 3'd0;
			fetch_ff <= 1'b0;
			fetch2_ff <= 1'b0;
			cmd_code <= `CMD_RESET_VAL;
			cmd_addr <= {AW{1'b0}};
			cmd_valid <= 1'b0;
			wr_data <= 8'h00;
			wr_data_valid <= 1'b0;
			cmd_abort <= 1'b0;
			so_out <= 1'b0;
			so_oe <= 1'b0;
			si_out <= 1'b0;
			si_oe <= 1'b0;
		end else if (ce) begin
			cmd_valid <= 1'b0;
			wr_data_valid <= 1'b0;
			cmd_abort <= 1'b0;
			fetch_ff <= 1'b0;
			// rom port is registered: new address at fetch, data one edge later
			fetch2_ff <= fetch_ff;
			if (fetch2_ff) begin
				obyte_ff <= rom_q;
			end
			if (sel_start) begin
				state_ff <= ST_OPC;
				bitcnt_ff <= 6'h00;
			end else if (sel_end) begin
				so_oe <= 1'b0;
				si_oe <= 1'b0;
				if (state_ff == ST_OPC || state_ff == ST_HDR) begin
					cmd_abort <= (state_ff == ST_HDR) || (bitcnt_ff != 6'h00);
				end else if (state_ff == ST_DATA && bitcnt_ff[2:0] == 3'd0) begin
					cmd_valid <= 1'b1;
				end
				state_ff <= ST_IDLE;
			end else if (rise) begin
				sh_ff <= sh_nxt;
				bitcnt_ff <= bitcnt_ff + 6'h01;
				case (state_ff)
					ST_OPC: begin
						if (byte_done) begin
							op_ff <= sh_nxt;
							cmd_code <= sh_nxt;
							case (op_class(sh_nxt))
								// unknown opcode: ignore rest of frame
								CL_NONE: state_ff <= ST_IGN;
								CL_OPONLY: begin
									cmd_valid <= 1'b1;
									state_ff <= ST_IGN;
								end
								CL_DATA: state_ff <= ST_DATA;
								CL_OUT: begin
									cmd_valid <= 1'b1;
									state_ff <= ST_IGN;
								end
								default: state_ff <= ST_HDR;
							endcase
						end
					end
					ST_HDR: begin
						if (bitcnt_ff < `ADDR_END_BITS) begin
							addr_ff <= {addr_ff[AW-2:0], si_s};
						end
						if (bitcnt_ff == `ADDR_END_BITS - 6'h01) begin
							cmd_addr <= {addr_ff[AW-2:0], si_s};
							fetch_ff <= 1'b1;
						end
						if (bitcnt_ff == hdr_end(op_ff) - 6'h01) begin
							case (op_ff)
								`OP_READ_FAST, `OP_READ_SLOW, `OP_READ_DUAL: begin
									state_ff <= ST_READ;
									dual_ff <= (op_ff == `OP_READ_DUAL);
									opos_ff <= 3'd7;
									cmd_valid <= 1'b1;
								end
								`OP_PROGRAM, `OP_SEC_PROGRAM: state_ff <= ST_DATA;
								default: begin
									// erase and security read hand off here
									cmd_valid <= 1'b1;
									state_ff <= ST_IGN;
								end
							endcase
						end
					end
					ST_DATA: begin
						if (byte_done) begin
							wr_data <= sh_nxt;
							wr_data_valid <= 1'b1;
							// reset needs the confirm byte; one-byte forms stop here
							if (op_ff == `OP_RESET) begin
								cmd_valid <= (sh_nxt == `RESET_CONFIRM);
								state_ff <= ST_IGN;
							end else if (op_ff == `OP_STATUS_WR1 || op_ff == `OP_STATUS_WR2) begin
								cmd_valid <= 1'b1;
								state_ff <= ST_IGN;
							end
						end
					end
					default: begin
					end
				endcase
			end else if (fall && state_ff == ST_READ) begin
				so_oe <= 1'b1;
				si_oe <= dual_ff;
				so_out <= obyte_ff[opos_ff];
				si_out <= obyte_ff[opos_ff - 3'd1];
				if ((dual_ff && opos_ff == 3'd1) || (!dual_ff && opos_ff == 3'd0)) begin
					opos_ff <= 3'd7;
					addr_ff <= (addr_ff == `ADDR_TOP) ? {AW{1'b0}} : nxt_addr;
					fetch_ff <= 1'b1;
				end else begin
					opos_ff <= opos_ff - (dual_ff ? 3'd2 : 3'd1);
				end
			end
		end
	end
endmodule

// *** flash_front_assertions.sv ***
// checker for the serial flash front end ports
`timescale 1ns/1ns
`include "flash_front_regs.vh"
module flash_front_assertions #(
	parameter AW = `ADDR_WIDTH
) (
	input wire mclk,
	input wire arst_n,
	input wire ce,
	input wire cs_n,
	input wire sck,
	input wire si_in,
	input wire si_out,
	input wire si_oe,
	input wire so_out,
	input wire so_oe,
	input wire [7:0] cmd_code,
	input wire [AW-1:0] cmd_addr,
	input wire cmd_valid,
	input wire [7:0] wr_data,
	input wire wr_data_valid,
	input wire cmd_abort
);
	// ==========
	// properties
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// six cycles covers the two-stage chip select sync
	a_float_when_idle: assert property (cs_n [*6] |-> !so_oe && !si_oe)
		else $error("output enable while deselected");
	a_dual_line_owner: assert property (si_oe |-> so_oe && cmd_code == `OP_READ_DUAL)
		else $error("second data line driven outside dual read");
	a_so_only_read: assert property (so_oe |->
		cmd_code inside {`OP_READ_FAST, `OP_READ_SLOW, `OP_READ_DUAL})
		else $error("serial output driven outside a read");
	a_so_falling_only: assert property (so_oe && $past(so_oe) && so_out != $past(so_out)
		|-> !$past(sck))
		else $error("serial output changed while clock high");
	a_si_falling_only: assert property (si_oe && $past(si_oe) && si_out != $past(si_out)
		|-> !$past(sck))
		else $error("second data line changed while clock high");
	a_valid_one_cycle: assert property (cmd_valid |=> !cmd_valid)
		else $error("command pulse too long");
	a_abort_excl: assert property (cmd_abort |-> !cmd_valid ##1 !cmd_abort)
		else $error("abort pulse wrong");
	a_write_byte_op: assert property (wr_data_valid |-> cmd_code inside {`OP_PROGRAM,
		`OP_SEC_PROGRAM, `OP_STATUS_WR1, `OP_STATUS_WR2, `OP_RESET})
		else $error("payload byte for a command without data");
endmodule

// *** spi_host_model.sv ***
// mode 0 host controller model for the serial flash
`timescale 1ns/1ns
module spi_host_model (
	input wire mclk,
	input wire so_out,
	input wire second_data_line,
	output reg cs_n,
	output reg sck,
	output reg si_drv
);
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si_drv = 1'b0;
	end
	// 80 ns clock stays below every limit
	task slot(input b, input dual, output [1:0] rx);
	begin
		@(negedge mclk);
		sck = 1'b0;
		si_drv = dual ? ~si_drv : b;
		repeat (4) @(negedge mclk);
		sck = 1'b1;
		repeat (3) @(negedge mclk);
		rx = {so_out, second_data_line};
	end
	endtask
	task sel;
	begin
		@(negedge mclk);
		cs_n = 1'b0;
		repeat (4) @(negedge mclk);
	end
	endtask
	// clock parked low before release; input line left changing
	task desel;
	begin
		repeat (4) @(negedge mclk);
		sck = 1'b0;
		repeat (4) @(negedge mclk);
		cs_n = 1'b1;
		si_drv = ~si_drv;
		repeat (8) @(negedge mclk);
	end
	endtask
	task xbyte(input [7:0] tx, input dual, output [7:0] rx);
		integer i;
		reg [1:0] r;
	begin
		rx = 8'h00;
		for (i = 0; i < (dual ? 4 : 8); i = i + 1) begin
			slot(tx[7 - i], dual, r);
			rx = dual ? {rx[5:0], r} : {rx[6:0], r[1]};
		end
	end
	endtask
endmodule

// *** flash_front_tb_top.sv ***
// self-checking bench for the serial flash front end
`timescale 1ns/1ns
`include "flash_front_regs.vh"
module flash_front_tb_top;
	reg mclk = 1'b0;
	reg arst_n = 1'b0;
	wire cs_n, sck, si_drv, second_data_line, si_out, si_oe, so_out, so_oe;
	wire cmd_valid, wr_data_valid, cmd_abort;
	wire [7:0] cmd_code, wr_data;
	wire [`ADDR_WIDTH-1:0] cmd_addr;
	integer failures = 0;
	integer num_checks = 0;
	integer seed = 32'h49c4;
	integer n_valid = 0;
	integer n_abort = 0;
	integer i, k;
	reg [7:0] got_code, got_wr, rx, op, b;
	reg [`ADDR_WIDTH-1:0] got_addr;
	reg [23:0] full;
	// {opcode, payload flag, address flag, extra byte count}
	reg [16*21-1:0] tbl = {16'h8110, 16'h2010, 16'h5210, 16'hD810, 16'h6000, 16'hC700,
		16'h6200, 16'h0231, 16'h0600, 16'h0400, 16'h9B31, 16'h7712, 16'h0500, 16'h0121,
		16'h3121, 16'hF001, 16'h9F00, 16'h1500, 16'hB900, 16'hAB00, 16'h7900};
	// shared pin level from both drivers
	assign second_data_line = si_oe ? si_out : si_drv;
	initial forever #5 mclk = ~mclk;
	spi_host_model i_host (.mclk(mclk), .so_out(so_out), .second_data_line(second_data_line), .cs_n(cs_n), .sck(sck),
		.si_drv(si_drv));
	flash_front i_dut (.mclk(mclk), .arst_n(arst_n), .ce(1'b1), .cs_n(cs_n), .sck(sck),
		.si_in(second_data_line), .si_out(si_out), .si_oe(si_oe), .so_out(so_out), .so_oe(so_oe),
		.cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_valid(cmd_valid), .wr_data(wr_data),
		.wr_data_valid(wr_data_valid), .cmd_abort(cmd_abort));
	// ==========
	// monitors and helpers
	always @(posedge mclk) begin
		if (cmd_valid === 1'b1) begin
			n_valid = n_valid + 1;
			got_code = cmd_code;
			got_addr = cmd_addr;
		end
		if (wr_data_valid === 1'b1)
			got_wr = wr_data;
		if (cmd_abort === 1'b1)
			n_abort = n_abort + 1;
	end
	function [7:0] exp_byte(input [`ADDR_WIDTH-1:0] a);
		exp_byte = a[7:0] ^ {1'b0, a[14:8]};
	endfunction
	task chk(input [31:0] seen, input [31:0] want);
	begin
		num_checks = num_checks + 1;
		if (seen !== want) begin
			failures = failures + 1;
			$display("BAD %0t seen %0h expected %0h", $time, seen, want);
		end
	end
	endtask
	task rd(input [7:0] o, input [23:0] ad, input integer n);
		reg dual;
	begin
		dual = (o == `OP_READ_DUAL);
		i_host.sel;
		i_host.xbyte(o, 1'b0, rx);
		for (k = 16; k >= 0; k = k - 8)
			i_host.xbyte(ad[k +: 8], 1'b0, rx);
		b = $random(seed);
		if (o != `OP_READ_SLOW)
			i_host.xbyte(b, 1'b0, rx);
		for (k = 0; k < n; k = k + 1) begin
			i_host.xbyte(8'h00, dual, rx);
			chk(rx, exp_byte(ad[14:0] + k));
		end
		// end the read in mid-byte
		i_host.slot(1'b0, dual, rx[1:0]);
		i_host.desel;
		chk({so_oe, si_oe}, 2'b00);
	end
	endtask
	task cmd(input [15:0] e);
	begin
		op = e[15:8];
		full = $random(seed);
		b = (op == `OP_RESET) ? `RESET_CONFIRM : $random(seed);
		n_valid = 0;
		i_host.sel;
		i_host.xbyte(op, 1'b0, rx);
		if (e[4])
			for (k = 16; k >= 0; k = k - 8)
				i_host.xbyte(full[k +: 8], 1'b0, rx);
		for (k = 0; k < e[3:0]; k = k + 1)
			i_host.xbyte(b, 1'b0, rx);
		i_host.desel;
		chk(n_valid, 1);
		chk(got_code, op);
		if (e[4])
			chk(got_addr, full[14:0]);
		if (e[5])
			chk(got_wr, b);
	end
	endtask
	task end_of_test;
	begin
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask
	// ==========
	// main sequence
	initial begin
		repeat (3) @(negedge mclk);
		arst_n = 1'b1;
		repeat (3) @(negedge mclk);
		chk({so_oe, si_oe, cmd_valid, cmd_abort}, 4'h0);
		rd(`OP_READ_SLOW, $random(seed), 3);
		rd(`OP_READ_FAST, {$random(seed), 15'h7FFE}, 3);
		rd(`OP_READ_DUAL, 24'h007FFF, 2);
		for (i = 0; i < 6; i = i + 1)
			rd(i % 3 == 0 ? `OP_READ_SLOW : i % 3 == 1 ? `OP_READ_FAST : `OP_READ_DUAL,
				$random(seed), 2);
		for (i = 20; i >= 0; i = i - 1)
			cmd(tbl[16*i +: 16]);
		// unknown opcode, then bytes that look like commands
		n_valid = 0;
		i_host.sel;
		i_host.xbyte(8'hFF, 1'b0, rx);
		i_host.xbyte(`OP_WR_ENABLE, 1'b0, rx);
		i_host.xbyte(`OP_READ_SLOW, 1'b0, rx);
		i_host.desel;
		chk(n_valid, 0);
		n_abort = 0;
		i_host.sel;
		i_host.xbyte(`OP_BLK4_ERASE, 1'b0, rx);
		i_host.xbyte(8'h12, 1'b0, rx);
		i_host.desel;
		chk(n_valid, 0);
		chk(n_abort, 1);
		cmd(16'h0600);
		end_of_test;
	end
	initial begin
		#900000;
		failures = failures + 1;
		end_of_test;
	end
endmodule
bind flash_front flash_front_assertions #(.AW(AW)) i_chk (.mclk(mclk), .arst_n(arst_n),
	.ce(ce), .cs_n(cs_n), .sck(sck), .si_in(si_in), .si_out(si_out), .si_oe(si_oe),
	.so_out(so_out), .so_oe(so_oe), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
	.cmd_valid(cmd_valid), .wr_data(wr_data), .wr_data_valid(wr_data_valid),
	.cmd_abort(cmd_abort));
